/* File: core/camera_trigger_qualifier.v */
// Trigger qualification for an area-scan camera: source select, line edge or
// level check, microsecond delay, overlap policy, logical line map, Avalon-MM regs.
// Assumes exposure/readout status and the counter-one done pulse come from logic on
// i_core_clk; input lines are asynchronous pins.
//
// Contract
// - Counter one done event is a selectable internal trigger origin.
// - Activation mode applies only to line origins, ignored for internal origins.
// - Edge modes fire on rise, fall or both, after the line inverter.
// - Level modes fire while the line is high, or while it is low.
// - Wait a programmable 0 to 2000000 microseconds before the trigger event.
// - Overlap policy decides whether a new trigger is accepted during readout.
// - Overlap off rejects triggers while exposure or readout is in progress.
// - Readout overlap accepts a new trigger once readout has begun.
// - End-of-exposure overlap accepts a new trigger right after exposure ends.
// - End-of-exposure overlap holds the trigger if exposure would end before readout.
// - Logical lines one and two map to the two input pins.
// - Logical lines three and four map to outputs on shared output power.
// - Only one-input three-output variants offer line five as third output.
// - Each selected logical line reads back a label naming input or output.
// - Selected trigger origin acts only while the trigger gate is on.
// - Software trigger command fires at once whatever origin is selected; the code still passes it through the trigger wait and the overlap policy.
`timescale 1ns/10ps
`include "trig_qual_consts.vh"

module camera_trigger_qualifier #(
  parameter THREE_OUT_VARIANT = 0,
  parameter TICK_DIV          = `TICKS_PER_US
) (
  input  wire        i_core_clk,
  input  wire        i_rst,
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  input  wire [1:0]  i_line_in,
  input  wire        i_counter_one_done,
  input  wire        i_exposure_active,
  input  wire        i_readout_active,
  input  wire        i_exposure_ends_early,
  output wire        o_frame_trigger,
  output wire [2:0]  o_line_out
);

  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_HOLD = 2'd2;

  // Label of a logical line index; depends on the model variant
  function [2:0] line_label;
    input [2:0] idx;
    begin
      case (idx)
        3'd1:    line_label = `LABEL_INPUT1;
        3'd2:    line_label = THREE_OUT_VARIANT ? `LABEL_NONE : `LABEL_INPUT2;
        3'd3:    line_label = `LABEL_OUTPUT1;
        3'd4:    line_label = `LABEL_OUTPUT2;
        3'd5:    line_label = THREE_OUT_VARIANT ? `LABEL_OUTPUT3 : `LABEL_NONE;
        default: line_label = `LABEL_NONE;
      endcase
    end
  endfunction

  reg  [8:0]  ctrl_ff;
  reg  [20:0] trig_wait_us_ff;
  reg  [2:0]  line_index_select_ff;
  reg  [1:0]  invert_ff;
  reg  [2:0]  out_value_ff;
  reg         ack_ff;
  reg  [31:0] readdata_ff;
  reg  [31:0] nxt_readdata;
  reg  [1:0]  line_meta_ff;
  reg  [1:0]  line_sync_ff;
  reg  [1:0]  line_prev_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [20:0] us_left_ff;
  reg  [20:0] nxt_us_left;
  reg  [7:0]  presc_ff;
  reg  [7:0]  nxt_presc;
  reg         fire_ff;
  reg         nxt_fire;
  reg         sw_cmd_ff;
  reg         line_hit;
  reg         origin_hit;

  wire        trig_gate_on;
  wire [2:0]  trig_origin_select;
  wire [2:0]  line_trigger_activation;
  wire [1:0]  trig_overlap_policy;
  wire        bus_req;
  wire        wr_take;
  wire [1:0]  line_q;
  wire [1:0]  line_rise;
  wire [1:0]  line_fall;
  wire        sel_line;
  wire        sel_rise;
  wire        sel_fall;
  wire        sel_level;
  wire        accept_ok;
  wire        need_hold;
  wire        tick;
  wire        trig_in;
  wire [2:0]  sel_label;

  assign trig_gate_on            = ctrl_ff[`CTRL_GATE_BIT];
  assign trig_origin_select      = ctrl_ff[`CTRL_ORIGIN_MSB:`CTRL_ORIGIN_LSB];
  assign line_trigger_activation = ctrl_ff[`CTRL_ACT_MSB:`CTRL_ACT_LSB];
  assign trig_overlap_policy     = ctrl_ff[`CTRL_OVL_MSB:`CTRL_OVL_LSB];

  // One wait cycle per access; the second cycle completes it
  assign bus_req           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack_ff;
  assign wr_take           = i_avs_write & ack_ff;
  assign o_avs_readdata    = readdata_ff;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // Register writes, taken only on the completing cycle
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_ff              <= `RST_CTRL;
      trig_wait_us_ff      <= `RST_DELAY;
      line_index_select_ff <= `RST_LINE_SEL;
      invert_ff            <= `RST_INVERT;
      out_value_ff         <= `RST_OUT_VALUE;
      sw_cmd_ff            <= 1'b0;
    end else begin
      sw_cmd_ff <= wr_take && (i_avs_address == `REG_SW_CMD) && i_avs_writedata[0];
      if (wr_take) begin
        case (i_avs_address)
          `REG_CTRL: begin
            ctrl_ff <= i_avs_writedata[8:0];
          end
          `REG_DELAY: begin
            // Clamp keeps the delay inside its legal span
            if (i_avs_writedata > `TRIG_WAIT_MAX_US) begin
              trig_wait_us_ff <= `TRIG_WAIT_CLAMP;
            end else begin
              trig_wait_us_ff <= i_avs_writedata[20:0];
            end
          end
          `REG_LINE_SEL: begin
            line_index_select_ff <= i_avs_writedata[2:0];
          end
          `REG_INVERT: begin
            invert_ff <= i_avs_writedata[1:0];
          end
          `REG_OUT_VALUE: begin
            out_value_ff <= i_avs_writedata[2:0];
          end
          default: begin
            invert_ff <= invert_ff;
          end
        endcase
      end
    end
  end

  // Readback of the selected line's label and status
  assign sel_label = line_label(line_index_select_ff);

  // Read mux; unmapped addresses read as zero
  always @* begin
    nxt_readdata = 32'h0000_0000;
    case (i_avs_address)
      `REG_CTRL:      nxt_readdata[8:0]  = ctrl_ff;
      `REG_DELAY:     nxt_readdata[20:0] = trig_wait_us_ff;
      `REG_LINE_SEL: begin
        nxt_readdata[2:0]  = line_index_select_ff;
        nxt_readdata[10:8] = sel_label;
        nxt_readdata[12]   = (sel_label >= `LABEL_OUTPUT1);
        nxt_readdata[13]   = (sel_label != `LABEL_NONE);
      end
      `REG_STATUS: begin
        nxt_readdata[0]    = line_q[0];
        nxt_readdata[1]    = THREE_OUT_VARIANT ? 1'b0 : line_q[1];
        nxt_readdata[3:2]  = out_value_ff[1:0];
        nxt_readdata[4]    = THREE_OUT_VARIANT ? out_value_ff[2] : 1'b0;
        nxt_readdata[8]    = (state_ff == S_WAIT);
        nxt_readdata[9]    = (state_ff == S_HOLD);
        nxt_readdata[10]   = ~accept_ok;
      end
      `REG_INVERT:    nxt_readdata[1:0]  = invert_ff;
      `REG_OUT_VALUE: nxt_readdata[2:0]  = out_value_ff;
      default:        nxt_readdata       = 32'h0000_0000;
    endcase
  end

  // Read data registered; stands from the wait cycle to the completing edge
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      readdata_ff <= 32'h0000_0000;
    end else begin
      readdata_ff <= nxt_readdata;
    end
  end

  // Output pins; line five exists only on the three-output variant
  assign o_line_out[0] = out_value_ff[0];
  assign o_line_out[1] = out_value_ff[1];
  assign o_line_out[2] = THREE_OUT_VARIANT ? out_value_ff[2] : 1'b0;

  // Two-stage synchroniser on the asynchronous input pins
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      line_meta_ff <= 2'b00;
      line_sync_ff <= 2'b00;
      line_prev_ff <= 2'b00;
    end else begin
      line_meta_ff <= i_line_in;
      line_sync_ff <= line_meta_ff;
      line_prev_ff <= line_q;
    end
  end

  // Inverter ahead of edge detection, so edges are of the inverted signal
  assign line_q    = line_sync_ff ^ invert_ff;
  assign line_rise = line_q & ~line_prev_ff;
  assign line_fall = ~line_q & line_prev_ff;

  // Selected line and its edges; line two unless the origin is line one
  assign sel_line  = (trig_origin_select == `ORIGIN_LINE1) ? line_q[0] : line_q[1];
  assign sel_rise  = (trig_origin_select == `ORIGIN_LINE1) ? line_rise[0] : line_rise[1];
  assign sel_fall  = (trig_origin_select == `ORIGIN_LINE1) ? line_fall[0] : line_fall[1];
  assign sel_level = sel_line;

  // Activation check of the selected line
  always @* begin
    case (line_trigger_activation)
      `ACT_RISE:       line_hit = sel_rise;
      `ACT_FALL:       line_hit = sel_fall;
      `ACT_BOTH_EDGES: line_hit = sel_rise | sel_fall;
      `ACT_HIGH:       line_hit = sel_level;
      `ACT_LOW:        line_hit = ~sel_level;
      default:         line_hit = 1'b0;
    endcase
  end

  // Origin select; activation mode only looks at line origins
  always @* begin
    case (trig_origin_select)
      `ORIGIN_LINE1:       origin_hit = line_hit;
      `ORIGIN_LINE2:       origin_hit = THREE_OUT_VARIANT ? 1'b0 : line_hit;
      `ORIGIN_COUNTER_ONE: origin_hit = i_counter_one_done;
      default:             origin_hit = 1'b0;
    endcase
  end

  // Gate blocks the selected origin only; the software command bypasses it
  assign trig_in = (trig_gate_on & origin_hit) | sw_cmd_ff;

  // Busy delay or hold always rejects; otherwise the policy decides
  assign accept_ok = (trig_overlap_policy == `OVL_OFF) ?
                     ~(i_exposure_active | i_readout_active) :
                     ~i_exposure_active;

  // Postpone only when the new exposure would finish ahead of the readout
  assign need_hold = (trig_overlap_policy == `OVL_AFTER_EXP_END) &
                     i_readout_active & i_exposure_ends_early;

  // Microsecond tick from the core clock
  // Prescaler is 8 bits, so TICK_DIV must lie between 1 and 256
  assign tick = (presc_ff == TICK_DIV[7:0] - 8'd1);

  // Delay and hold sequencer
  always @* begin
    nxt_state   = state_ff;
    nxt_us_left = us_left_ff;
    nxt_presc   = tick ? 8'd0 : presc_ff + 8'd1;
    nxt_fire    = 1'b0;
    case (state_ff)
      S_IDLE: begin
        nxt_presc = 8'd0;
        // Nothing is taken in the pulse cycle: the frame just fired is not
        // yet visible on the exposure input, so a level would fire twice
        if (trig_in && accept_ok && !fire_ff) begin
          if (trig_wait_us_ff == 21'd0) begin
            if (need_hold) begin
              nxt_state = S_HOLD;
            end else begin
              nxt_fire = 1'b1;
            end
          end else begin
            nxt_us_left = trig_wait_us_ff;
            nxt_state   = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (tick) begin
          nxt_us_left = us_left_ff - 21'd1;
          if (us_left_ff == 21'd1) begin
            if (need_hold) begin
              nxt_state = S_HOLD;
            end else begin
              nxt_fire  = 1'b1;
              nxt_state = S_IDLE;
            end
          end
        end
      end
      S_HOLD: begin
        nxt_presc = 8'd0;
        if (!need_hold) begin
          nxt_fire  = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_ff   <= S_IDLE;
      us_left_ff <= 21'd0;
      presc_ff   <= 8'd0;
      fire_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      us_left_ff <= nxt_us_left;
      presc_ff   <= nxt_presc;
      fire_ff    <= nxt_fire;
    end
  end

  // Registered pulse, one cycle wide
  assign o_frame_trigger = fire_ff;

endmodule

/* File: core/trig_qual_consts.vh */
// Constants for the camera trigger qualifier: register offsets, field positions,
// reset values, encodings and timing counts. Included by the design, checker and bench files.
`ifndef TRIG_QUAL_CONSTS_VH
`define TRIG_QUAL_CONSTS_VH

// Register word offsets, one aligned 32-bit word each
`define REG_CTRL            4'h0
`define REG_DELAY           4'h1
`define REG_SW_CMD          4'h2
`define REG_LINE_SEL        4'h3
`define REG_STATUS          4'h4
`define REG_INVERT          4'h5
`define REG_OUT_VALUE       4'h6

// Control word fields
`define CTRL_GATE_BIT       0
`define CTRL_ORIGIN_LSB     1
`define CTRL_ORIGIN_MSB     3
`define CTRL_ACT_LSB        4
`define CTRL_ACT_MSB        6
`define CTRL_OVL_LSB        7
`define CTRL_OVL_MSB        8

// Trigger origin codes
`define ORIGIN_SW           3'h0
`define ORIGIN_LINE1        3'h1
`define ORIGIN_LINE2        3'h2
`define ORIGIN_COUNTER_ONE  3'h3

// Line trigger activation codes
`define ACT_RISE            3'h0
`define ACT_FALL            3'h1
`define ACT_BOTH_EDGES      3'h2
`define ACT_HIGH            3'h3
`define ACT_LOW             3'h4

// Overlap policy codes
`define OVL_OFF             2'h0
`define OVL_READOUT         2'h1
`define OVL_AFTER_EXP_END   2'h2

// Line label codes
`define LABEL_NONE          3'h0
`define LABEL_INPUT1        3'h1
`define LABEL_INPUT2        3'h2
`define LABEL_OUTPUT1       3'h3
`define LABEL_OUTPUT2       3'h4
`define LABEL_OUTPUT3       3'h5

// Reset values
`define RST_CTRL            9'h000
`define RST_DELAY           21'h00_0000
`define RST_LINE_SEL        3'h1
`define RST_INVERT          2'h0
`define RST_OUT_VALUE       3'h0

// Timing
`define CLK_FREQ_MHZ        200
`define TRIG_WAIT_MAX_US    2000000
`define TRIG_WAIT_CLAMP     21'h1E_8480
`define TICKS_PER_US        (`CLK_FREQ_MHZ)

`endif

/* File: tb/camera_trigger_qualifier_asserts.sv */
// Checker for the trigger qualifier: bus answer, pulse shape, gating of triggers.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`include "trig_qual_consts.vh"
module trig_qual_checker #(
  parameter THREE_OUT_VARIANT = 0,
  parameter TICK_DIV          = 200
) (
  input wire        i_core_clk,
  input wire        i_rst,
  input wire [3:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire        o_avs_waitrequest,
  input wire        i_exposure_active,
  input wire        i_readout_active,
  input wire        o_frame_trigger,
  input wire [2:0]  o_line_out
);
  reg  [8:0]  ctrl_ff;
  reg  [20:0] dly_ff;
  wire        done = i_avs_write && !o_avs_waitrequest;
  wire        sw_done = done && i_avs_address == `REG_SW_CMD && i_avs_writedata[0];
  wire        cfg0 = !ctrl_ff[0] && dly_ff == 21'h00_0000 && ctrl_ff[8:7] != `OVL_AFTER_EXP_END;
  wire        quiet = cfg0 && !sw_done;
  wire        busy = i_exposure_active || i_readout_active;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Shadow words; only zero or nonzero delay matters, so the clamp is ignored
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_ff <= 9'h000;
      dly_ff  <= 21'h00_0000;
    end else if (done && i_avs_address == `REG_CTRL) begin
      ctrl_ff <= i_avs_writedata[8:0];
    end else if (done && i_avs_address == `REG_DELAY) begin
      dly_ff <= i_avs_writedata[20:0];
    end
  end
  property p_wait_ans;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("late bus answer");
  property p_wait_idle;
    !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait while idle");
  property p_pulse;
    o_frame_trigger |=> !o_frame_trigger;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger pulse too long");
  property p_out_off;
    THREE_OUT_VARIANT == 0 |-> o_line_out[2] == 1'b0;
  endproperty
  a_out_off: assert property (p_out_off) else $error("absent output driven");
  property p_out_follow;
    done && i_avs_address == `REG_OUT_VALUE |=> o_line_out[1:0] == $past(i_avs_writedata[1:0]);
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("outputs not updated");
  property p_sw_zero;
    sw_done && cfg0 ##1 !busy |-> ##1 o_frame_trigger;
  endproperty
  a_sw_zero: assert property (p_sw_zero) else $error("software trigger lost");
  property p_gate_off;
    quiet [*3] |-> !o_frame_trigger;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("trigger with gate off");
  property p_ovl_off;
    (ctrl_ff[8:7] == `OVL_OFF && dly_ff == 21'h00_0000 && busy) [*3] |-> !o_frame_trigger;
  endproperty
  a_ovl_off: assert property (p_ovl_off) else $error("overlap accepted");
  c_sw: cover property (sw_done);
  c_overlap: cover property (o_frame_trigger && i_readout_active);
  c_ctrl: cover property (done && i_avs_address == `REG_CTRL);
endmodule
bind camera_trigger_qualifier trig_qual_checker #(
  .THREE_OUT_VARIANT(THREE_OUT_VARIANT), .TICK_DIV(TICK_DIV)) u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_exposure_active(i_exposure_active),
  .i_readout_active(i_readout_active), .o_frame_trigger(o_frame_trigger),
  .o_line_out(o_line_out));

/* File: tb/camera_trigger_qualifier_bench.sv */
// Bench for the trigger qualifier: registers, sources, line modes, overlap.
// Assumes the far-side model makes pins and frame timing; tick divider set to 2.
`timescale 1ns/10ps
`include "trig_qual_consts.vh"
module camera_trigger_qualifier_bench;
  localparam TD = 2;
  logic        clk, rst, rd, wr, cnt, shrt;
  logic [3:0]  adr;
  logic [31:0] wd, q;
  logic [1:0]  pins;
  wire  [31:0] rdata;
  wire         wait_req, ftrig, ctr, expo, rdo, early;
  wire  [1:0]  lines;
  wire  [2:0]  lout;
  int          failures, compares, n;
  logic [6:0]  cases [11] = '{7'h60, 7'h10, 7'h51, 7'h21, 7'h62, 7'h52, 7'h73, 7'h03,
                              7'h44, 7'h34, 7'h58};
  logic [15:0] labels [8] = '{16'h0000, 16'h2101, 16'h2202, 16'h3303, 16'h3404,
                              16'h0005, 16'h0006, 16'h0007};
  camera_trigger_qualifier #(.THREE_OUT_VARIANT(0), .TICK_DIV(TD)) u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_line_in(lines), .i_counter_one_done(ctr),
    .i_exposure_active(expo), .i_readout_active(rdo), .i_exposure_ends_early(early),
    .o_frame_trigger(ftrig), .o_line_out(lout));
  trig_far_side u_far (
    .i_core_clk(clk), .i_rst(rst), .i_pin_cmd(pins), .i_cnt_cmd(cnt), .i_short_exp(shrt),
    .i_frame_trigger(ftrig), .o_line_in(lines), .o_counter_one_done(ctr),
    .o_exposure_active(expo), .o_readout_active(rdo), .o_exposure_ends_early(early));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus access; the request stays up until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    #1;
    while (wait_req !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    // Read data taken at the completing edge, then the request is dropped
    @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    cmp("register", exp, q);
  endtask
  // Counts cycles until a frame pulse shows, giving up at the limit
  task automatic wait_trig(input int lim);
    n = 0;
    #1;
    while (ftrig !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic sw(input int lim);
    bus(1'b1, `REG_SW_CMD, 32'h0000_0001);
    wait_trig(lim);
  endtask
  task automatic rest;
    repeat (80) @(posedge clk);
  endtask
  task automatic until_rd;
    do begin
      @(posedge clk);
      #1;
    end while (!(rdo === 1'b1 && expo === 1'b0));
  endtask
  // Case bits: expected, pin after, pin before, inverter, activation code
  task automatic line_case(input logic [6:0] t);
    bus(1'b1, `REG_CTRL, 32'h0000_0082);
    bus(1'b1, `REG_INVERT, {31'h0000_0000, t[3]});
    pins <= {1'b0, t[4]};
    rest;
    bus(1'b1, `REG_CTRL, {23'h00_0000, 2'b01, t[2:0], 4'h3});
    pins <= {1'b0, t[5]};
    wait_trig(12);
    cmp("line trigger", {31'h0000_0000, t[6]}, {31'h0000_0000, n < 12});
  endtask
  task automatic ctr_case(input logic [31:0] c, input logic e);
    bus(1'b1, `REG_CTRL, c);
    cnt <= 1'b1;
    @(posedge clk);
    cnt <= 1'b0;
    wait_trig(12);
    cmp("counter trigger", {31'h0000_0000, e}, {31'h0000_0000, n < 12});
    rest;
  endtask
  // Watchdog
  initial begin
    #200_000;
    failures++;
    summarize;
  end
  initial begin
    rst = 1'b1;
    {rd, wr, cnt, shrt, adr, wd, pins} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(`REG_CTRL, 32'h0000_0000);
    bus(1'b1, 4'h9, 32'hFFFF_FFFF);
    rchk(4'h9, 32'h0000_0000);
    bus(1'b1, `REG_DELAY, 32'h00FF_FFFF);
    rchk(`REG_DELAY, 32'h001E_8480);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `REG_LINE_SEL, 32'(i));
      rchk(`REG_LINE_SEL, {16'h0000, labels[i]});
    end
    bus(1'b1, `REG_OUT_VALUE, 32'h0000_0007);
    #1;
    cmp("line outputs", 32'h0000_0003, {29'h0000_0000, lout});
    rchk(`REG_STATUS, 32'h0000_000C);
    bus(1'b1, `REG_DELAY, 32'h0000_0000);
    bus(1'b1, `REG_CTRL, 32'h0000_0002);
    sw(20);
    cmp("trigger latency", 1, n);
    rest;
    bus(1'b1, `REG_DELAY, 32'h0000_0003);
    sw(20);
    cmp("trigger latency", 1 + 3 * TD, n);
    rest;
    bus(1'b1, `REG_DELAY, 32'h0000_0000);
    sw(20);
    sw(10);
    cmp("overlap reject", 10, n);
    until_rd;
    sw(10);
    cmp("overlap reject", 10, n);
    rest;
    bus(1'b1, `REG_CTRL, 32'h0000_0082);
    sw(20);
    sw(10);
    cmp("overlap reject", 10, n);
    until_rd;
    sw(20);
    cmp("overlap accept", 1, n);
    rest;
    bus(1'b1, `REG_CTRL, 32'h0000_0102);
    shrt <= 1'b1;
    sw(20);
    until_rd;
    sw(100);
    cmp("held trigger", 1, {31'h0000_0000, n > 1 && n < 100 && rdo === 1'b0});
    shrt <= 1'b0;
    rest;
    for (int i = 0; i < 11; i++) line_case(cases[i]);
    bus(1'b1, `REG_CTRL, 32'h0000_0082);
    rest;
    ctr_case(32'h0000_0097, 1'b1);
    ctr_case(32'h0000_0096, 1'b0);
    summarize;
  end
endmodule

/* File: tb/trig_far_side.sv */
// Far-side model: trigger pins, counter-one event and the sensor frame timing.
// Assumes the bench commands pin levels; each frame trigger opens an exposure.
`timescale 1ns/10ps
module trig_far_side #(
  parameter [7:0] EXP_CYC = 8'h14,
  parameter [7:0] RD_CYC  = 8'h28
) (
  input  wire       i_core_clk,
  input  wire       i_rst,
  input  wire [1:0] i_pin_cmd,
  input  wire       i_cnt_cmd,
  input  wire       i_short_exp,
  input  wire       i_frame_trigger,
  output reg  [1:0] o_line_in,
  output reg        o_counter_one_done,
  output wire       o_exposure_active,
  output wire       o_readout_active,
  output wire       o_exposure_ends_early
);
  reg [7:0] exp_ff;
  reg [7:0] rd_ff;
  assign o_exposure_active = exp_ff != 8'h00;
  assign o_readout_active = rd_ff != 8'h00;
  // Early-end flag only means something while a readout runs
  assign o_exposure_ends_early = i_short_exp && o_readout_active;
  // Readout follows exposure and may overlap the next exposure
  always @(posedge i_core_clk) begin
    o_line_in <= i_pin_cmd;
    o_counter_one_done <= i_cnt_cmd;
    if (i_rst) begin
      exp_ff <= 8'h00;
      rd_ff  <= 8'h00;
    end else begin
      if (i_frame_trigger) exp_ff <= EXP_CYC;
      else if (o_exposure_active) exp_ff <= exp_ff - 8'h01;
      if (exp_ff == 8'h01) rd_ff <= RD_CYC;
      else if (o_readout_active) rd_ff <= rd_ff - 8'h01;
    end
  end
endmodule
